// ### pkg/attr_cfg_pkg.sv
package attr_cfg_pkg;
	// attribute register word offsets (byte addresses, a9..a0)
	localparam logic [9:0] OFF_CONFIG_OPTION   = 10'h200;
	localparam logic [9:0] OFF_CONFIG_AND_STATE = 10'h202;
	localparam logic [9:0] OFF_LINE_SUBSTITUTE = 10'h204;
	localparam logic [9:0] OFF_SLOT_AND_UNIT   = 10'h206;
	localparam int         ADDR_W              = 11;
	localparam int         CFG_SEL_BIT         = 9;
	// config option fields
	localparam int         COR_SOFT_CLEAR_BIT_BIT      = 7;
	localparam int         COR_LEVEL_BIT       = 6;
	localparam int         COR_INDEX_MSB       = 5;
	localparam logic [5:0] COR_INDEX_RESET     = 6'h00;
	// config and status fields
	localparam int         CSR_CHANGED_BIT     = 7;
	localparam int         CSR_CHANGE_SIGNAL_ENABLE_BIT      = 6;
	localparam int         CSR_NARROW_BIT      = 5;
	localparam int         CSR_PWRSAVE_BIT     = 2;
	localparam int         CSR_INTPEND_BIT     = 1;
	// line substitute fields
	localparam int         PRR_RDY_CHG_BIT     = 5;
	localparam int         PRR_PROT_CHG_BIT    = 4;
	localparam int         PRR_ONE_HI_BIT      = 3;
	localparam int         PRR_ONE_LO_BIT      = 2;
	localparam int         PRR_RDY_BIT         = 1;
	localparam int         PRR_PROT_BIT        = 0;
	// slot and unit fields
	localparam int         SCR_DRIVE_BIT       = 4;
	// configuration index codes
	localparam logic [3:0] IDX_MEMORY          = 4'h0;
	localparam logic [3:0] IDX_IO_ANY          = 4'h1;
	localparam logic [3:0] IDX_IO_PRIMARY      = 4'h2;
	localparam logic [3:0] IDX_IO_SECONDARY    = 4'h3;
	typedef enum logic [1:0] {
		MAP_MEMORY,
		MAP_IO_ANY,
		MAP_IO_PRIMARY,
		MAP_IO_SECONDARY
	} map_mode_t;
	// power state machine
	typedef enum logic [1:0] {
		PWR_ACTIVE,
		PWR_TO_SAVE,
		PWR_SAVE,
		PWR_TO_ACTIVE
	} pwr_state_t;
	// power transition time and idle time before auto power-save
	localparam int         PWR_SWITCH_NS       = 1000;
	localparam int         CLK_PERIOD_NS       = 5;
	localparam int         PWR_SWITCH_CYC      = (PWR_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         IDLE_DOWN_CYC       = 100000;
endpackage : attr_cfg_pkg

// ### pkg/strobe_sync_if.sv
`timescale 1ns/1ps
// synchronised host strobes travelling from the pin stage into the decoder
interface strobe_sync_if;
	logic reg_sel_n;
	logic low_en_n;
	logic high_en_n;
	logic rd_n;
	logic wr_n;
	modport src (output reg_sel_n, low_en_n, high_en_n, rd_n, wr_n);
	modport dst (input  reg_sel_n, low_en_n, high_en_n, rd_n, wr_n);
endinterface : strobe_sync_if

// ### design/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin levels
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] reset_val,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	// first stage read only by the second
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_r   <= reset_val;
			sync_out <= reset_val;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : pin_sync

// ### design/attribute_config_regs.sv
`timescale 1ns/1ps
// How it works
// - attribute access byte wide, even only unless high byte enabled
// - data valid only on low byte
// - a9 low table, high registers
// - table writes are ignored
// - config option register at 200h
// - soft reset holds block in reset
// - soft reset cleared by hard reset
// - interrupt mode bit picks level/pulse
// - index decodes memory or three io maps
// - config and status register at 202h
// - changed flag ors the change latches
// - status change pin low when enabled
// - narrow io bit stored, ignored
// - power-save change shows busy until done
// - auto power-save on idle, wake on command
// - pending bit mirrors gated interrupt request
// - line substitute register at 204h
// - toggling live state sets change latch
// - masked load of change latches
// - slot register at 206h keeps drive bit
module attribute_config_regs
	import attr_cfg_pkg::*;
#(
	parameter int IDLE_CYC   = IDLE_DOWN_CYC,
	parameter int SWITCH_CYC = PWR_SWITCH_CYC
) (
	// system
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// host bus pins
	input  wire logic              reg_sel_n,
	input  wire logic              low_byte_enable_n,
	input  wire logic              high_byte_enable_n,
	input  wire logic              rd_n,
	input  wire logic              wr_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [15:0]       data_in,
	output logic      [15:0]       data_out,
	output logic                   data_lo_oe,
	output logic                   data_hi_oe,
	// status change pin and interrupt pin
	output logic                   status_change_out_n,
	output logic                   irq_out_n,
	// card information table port
	output logic      [7:0]        card_info_table_addr,
	input  wire logic [7:0]        card_info_table_data,
	// core side
	input  wire logic              core_irq_req,
	input  wire logic              irq_disable_n,
	input  wire logic              core_busy,
	input  wire logic              host_command,
	output logic                   core_reset,
	output logic                   power_save,
	output logic                   ready_out,
	output map_mode_t              map_mode,
	output logic                   drive_number
);
	strobe_sync_if sb ();
	logic [ADDR_W-1:0] addr_m_r, addr_s_r;
	logic [7:0]        wdat_m_r, wdat_s_r;

	// strobes idle high during reset
	pin_sync #(.W(5)) u_sync (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.async_in  ({reg_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n}),
		.reset_val (5'h1F),
		.sync_out  ({sb.reg_sel_n, sb.low_en_n, sb.high_en_n, sb.rd_n, sb.wr_n})
	);

	// address and data follow the strobes through two stages
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			addr_m_r <= '0;
			addr_s_r <= '0;
			wdat_m_r <= 8'h00;
			wdat_s_r <= 8'h00;
		end else begin
			addr_m_r <= addr;
			addr_s_r <= addr_m_r;
			wdat_m_r <= data_in[7:0];
			wdat_s_r <= wdat_m_r;
		end
	end

	// access decode
	logic attr_sel, rd_act, wr_act, wr_act_d_r, wr_pulse, cfg_space, odd_addr;
	assign odd_addr  = addr_s_r[0] && sb.high_en_n;
	assign attr_sel  = !sb.reg_sel_n && !sb.low_en_n && !odd_addr;
	assign rd_act    = attr_sel && !sb.rd_n && sb.wr_n;
	assign wr_act    = attr_sel && sb.rd_n && !sb.wr_n;
	assign cfg_space = addr_s_r[CFG_SEL_BIT];

	// one write per strobe; host releases between cycles
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_act_d_r <= 1'b0;
		end else begin
			wr_act_d_r <= wr_act;
		end
	end
	assign wr_pulse = wr_act && !wr_act_d_r;

	logic wr_cor, wr_csr, wr_prr, wr_scr;
	assign wr_cor = wr_pulse && cfg_space && addr_s_r[9:0] == OFF_CONFIG_OPTION;
	assign wr_csr = wr_pulse && cfg_space && addr_s_r[9:0] == OFF_CONFIG_AND_STATE;
	assign wr_prr = wr_pulse && cfg_space && addr_s_r[9:0] == OFF_LINE_SUBSTITUTE;
	assign wr_scr = wr_pulse && cfg_space && addr_s_r[9:0] == OFF_SLOT_AND_UNIT;

	// config option register
	logic       soft_clear_bit_r;
	logic       level_irq_select_r;
	logic [5:0] config_index_r;
	logic       blk_rst;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			soft_clear_bit_r <= 1'b0;
		end else if (wr_cor) begin
			soft_clear_bit_r <= wdat_s_r[COR_SOFT_CLEAR_BIT_BIT];
		end
	end
	// soft reset acts as hardware reset
	assign blk_rst = !rst_n || soft_clear_bit_r;
	assign core_reset = blk_rst;

	// mode and index; the write setting soft reset still clears them
	always_ff @(posedge sys_clk) begin
		if (blk_rst || (wr_cor && wdat_s_r[COR_SOFT_CLEAR_BIT_BIT])) begin
			level_irq_select_r <= 1'b0;
			config_index_r     <= COR_INDEX_RESET;
		end else if (wr_cor) begin
			level_irq_select_r <= wdat_s_r[COR_LEVEL_BIT];
			// reserved index bits stored as written
			config_index_r     <= wdat_s_r[COR_INDEX_MSB:0];
		end
	end

	logic io_mode;
	always_comb begin
		case (config_index_r[3:0])
			IDX_MEMORY:       map_mode = MAP_MEMORY;
			IDX_IO_ANY:       map_mode = MAP_IO_ANY;
			IDX_IO_PRIMARY:   map_mode = MAP_IO_PRIMARY;
			IDX_IO_SECONDARY: map_mode = MAP_IO_SECONDARY;
			default:          map_mode = MAP_MEMORY;
		endcase
	end
	assign io_mode = map_mode != MAP_MEMORY;

	// config and status register
	logic change_signal_enable_r, narrow_io_request_r, power_save_request_r;
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			change_signal_enable_r <= 1'b0;
			narrow_io_request_r    <= 1'b0;
			power_save_request_r   <= 1'b0;
		end else if (wr_csr) begin
			change_signal_enable_r <= wdat_s_r[CSR_CHANGE_SIGNAL_ENABLE_BIT];
			narrow_io_request_r    <= wdat_s_r[CSR_NARROW_BIT];
			power_save_request_r   <= wdat_s_r[CSR_PWRSAVE_BIT];
		end
	end

	// live ready and change latches
	logic ready_live_state, protect_live_state, ready_live_d_r;
	logic ready_change_latch_r, protect_change_latch_r, changed;
	assign protect_live_state = 1'b0; // no write protect switch
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			ready_live_d_r <= ready_live_state; // no false toggle after reset
		end else begin
			ready_live_d_r <= ready_live_state;
		end
	end

	// set wins over a masked clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			ready_change_latch_r <= 1'b0;
		end else if (ready_live_state != ready_live_d_r) begin
			ready_change_latch_r <= 1'b1;
		end else if (wr_prr && wdat_s_r[PRR_RDY_BIT]) begin
			ready_change_latch_r <= wdat_s_r[PRR_RDY_CHG_BIT];
		end
	end
	// protect line never toggles, so only host writes reach it
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			protect_change_latch_r <= 1'b0;
		end else if (wr_prr && wdat_s_r[PRR_PROT_BIT]) begin
			protect_change_latch_r <= wdat_s_r[PRR_PROT_CHG_BIT];
		end
	end
	assign changed = ready_change_latch_r || protect_change_latch_r;

	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			status_change_out_n <= 1'b1;
		end else begin
			status_change_out_n <= !(io_mode && change_signal_enable_r && changed);
		end
	end

	// slot and unit register
	logic drive_number_r;
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			drive_number_r <= 1'b0;
		end else if (wr_scr) begin
			// drive bit kept, socket bits ignored
			drive_number_r <= wdat_s_r[SCR_DRIVE_BIT];
		end
	end
	assign drive_number = drive_number_r;

	// power management
	pwr_state_t pwr_r;
	logic [31:0] pwr_cnt_r;
	logic        psr_d_r;
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			psr_d_r <= 1'b0;
		end else begin
			psr_d_r <= power_save_request_r;
		end
	end
	// request change drives a timed transition
	// idle count puts core to sleep, command wakes
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			pwr_r     <= PWR_ACTIVE;
			pwr_cnt_r <= 32'h0;
		end else begin
			case (pwr_r)
				PWR_ACTIVE: begin
					if (power_save_request_r && !psr_d_r) begin
						pwr_r     <= PWR_TO_SAVE;
						pwr_cnt_r <= 32'h0;
					end else if (host_command || core_busy) begin
						pwr_cnt_r <= 32'h0;
					end else if (pwr_cnt_r >= 32'(IDLE_CYC - 1)) begin
						pwr_r     <= PWR_TO_SAVE;
						pwr_cnt_r <= 32'h0;
					end else begin
						pwr_cnt_r <= pwr_cnt_r + 32'h1;
					end
				end
				PWR_TO_SAVE: begin
					if (pwr_cnt_r >= 32'(SWITCH_CYC - 1)) begin
						pwr_r     <= PWR_SAVE;
						pwr_cnt_r <= 32'h0;
					end else begin
						pwr_cnt_r <= pwr_cnt_r + 32'h1;
					end
				end
				PWR_SAVE: begin
					if ((!power_save_request_r && psr_d_r) || host_command) begin
						pwr_r     <= PWR_TO_ACTIVE;
						pwr_cnt_r <= 32'h0;
					end
				end
				PWR_TO_ACTIVE: begin
					if (pwr_cnt_r >= 32'(SWITCH_CYC - 1)) begin
						pwr_r     <= PWR_ACTIVE;
						pwr_cnt_r <= 32'h0;
					end else begin
						pwr_cnt_r <= pwr_cnt_r + 32'h1;
					end
				end
				default: begin
					pwr_r     <= PWR_ACTIVE;
					pwr_cnt_r <= 32'h0;
				end
			endcase
		end
	end
	assign power_save = pwr_r == PWR_SAVE;
	// busy while switching or core busy; ready shown when settled
	assign ready_live_state = !core_busy && (pwr_r == PWR_ACTIVE || pwr_r == PWR_SAVE);
	assign ready_out = ready_live_state;

	logic int_pending, irq_d_r;
	assign int_pending = core_irq_req && irq_disable_n;
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			irq_d_r   <= 1'b0;
			irq_out_n <= 1'b1;
		end else begin
			irq_d_r <= int_pending;
			// level holds, pulse gives one cycle
			if (level_irq_select_r) begin
				irq_out_n <= !(io_mode && int_pending);
			end else begin
				irq_out_n <= !(io_mode && int_pending && !irq_d_r);
			end
		end
	end

	// read mux
	logic [7:0] rd_byte;
	assign card_info_table_addr = addr_s_r[8:1];
	always_comb begin
		rd_byte = 8'h00;
		if (!cfg_space) begin
			rd_byte = card_info_table_data;
		end else begin
			case (addr_s_r[9:0])
				OFF_CONFIG_OPTION:
					rd_byte = {soft_clear_bit_r, level_irq_select_r, config_index_r};
				OFF_CONFIG_AND_STATE:
					rd_byte = {changed, change_signal_enable_r, narrow_io_request_r,
					           2'b00, power_save_request_r, int_pending, 1'b0};
				OFF_LINE_SUBSTITUTE:
					rd_byte = {2'b00, ready_change_latch_r, protect_change_latch_r,
					           2'b11, ready_live_state, protect_live_state};
				OFF_SLOT_AND_UNIT:
					rd_byte = {3'b000, drive_number_r, 4'h0};
				default:
					rd_byte = 8'h00;
			endcase
		end
	end

	// registered read data; upper byte zero and never enabled
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			data_out   <= 16'h0000;
			data_lo_oe <= 1'b0;
		end else begin
			data_out   <= {8'h00, rd_byte};
			data_lo_oe <= rd_act;
		end
	end
	assign data_hi_oe = 1'b0;
endmodule : attribute_config_regs

// ### bench/attr_cfg_checker_assertions.sv
`timescale 1ns/1ps
// port-level watcher of the attribute decoder
module attr_cfg_checker
	import attr_cfg_pkg::*;
(
	// system
	input wire logic              sys_clk,
	input wire logic              rst_n,
	// host pins
	input wire logic              reg_sel_n,
	input wire logic              low_byte_enable_n,
	input wire logic              high_byte_enable_n,
	input wire logic              rd_n,
	input wire logic              wr_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0]       data_in,
	input wire logic [15:0]       data_out,
	input wire logic              data_lo_oe,
	input wire logic              data_hi_oe,
	// status and core side
	input wire logic              status_change_out_n,
	input wire logic              irq_out_n,
	input wire logic              core_reset,
	input wire logic              power_save,
	input wire logic              ready_out,
	input wire map_mode_t         map_mode,
	input wire logic              drive_number
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// register write held three edges, long enough for the synced decode
	sequence cfg_wr(logic [9:0] off);
		(!reg_sel_n && !low_byte_enable_n && !wr_n && rd_n && addr[9:0] == off) [*3];
	endsequence
	// a read still in progress on the given register
	sequence cfg_rd(logic [9:0] off);
		data_lo_oe && !rd_n && $past(addr[9:0], 3) == off;
	endsequence
	chk_hi_byte_idle: assert property (data_out[15:8] == 8'h00 && !data_hi_oe)
		else $error("upper data byte driven");
	chk_oe_valid_read: assert property (data_lo_oe |-> !$past(rd_n, 3) && !$past(reg_sel_n, 3)
		&& !$past(low_byte_enable_n, 3) && !($past(addr[0], 3) && $past(high_byte_enable_n, 3)))
		else $error("data enabled without a valid attribute read");
	chk_sts_io_only: assert property (!status_change_out_n |-> $past(map_mode) != MAP_MEMORY)
		else $error("status change pin low in memory mode");
	chk_irq_io_only: assert property (!irq_out_n |-> $past(map_mode) != MAP_MEMORY)
		else $error("interrupt pin low in memory mode");
	chk_soft_rst_on: assert property (cfg_wr(OFF_CONFIG_OPTION) ##0 data_in[7] |-> ##[1:2] core_reset)
		else $error("soft reset bit did not hold core in reset");
	chk_index_map: assert property (cfg_wr(OFF_CONFIG_OPTION) ##0 (!data_in[7] && data_in[3:2] == 2'b00)
		|-> ##1 map_mode == map_mode_t'($past(data_in[1:0])))
		else $error("map mode does not follow index");
	chk_drive_hold: assert property (cfg_wr(OFF_SLOT_AND_UNIT) |-> ##1 drive_number == $past(data_in[4]))
		else $error("drive number not stored");
	chk_busy_save: assert property ($rose(power_save) |-> !$past(ready_out))
		else $error("power save reached without busy");
	chk_prr_fixed: assert property (cfg_rd(OFF_LINE_SUBSTITUTE)
		|-> data_out[7:6] == 2'b00 && data_out[3:2] == 2'b11 && !data_out[0])
		else $error("fixed line substitute bits wrong");
	chk_csr_zeros: assert property (cfg_rd(OFF_CONFIG_AND_STATE) |-> data_out[4:3] == 2'b00 && !data_out[0])
		else $error("reserved status bits not zero");
endmodule : attr_cfg_checker

bind attribute_config_regs attr_cfg_checker chk_u (.sys_clk, .rst_n, .reg_sel_n, .low_byte_enable_n,
	.high_byte_enable_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_lo_oe, .data_hi_oe,
	.status_change_out_n, .irq_out_n, .core_reset, .power_save, .ready_out, .map_mode,
	.drive_number);

// ### bench/host_socket_model.sv
`timescale 1ns/1ps
// host socket side of the attribute bus
module host_socket_model (
	// clock
	input wire logic         sys_clk,
	// host pins
	output logic             reg_sel_n,
	output logic             low_byte_enable_n,
	output logic             high_byte_enable_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic      [10:0] addr,
	output logic      [15:0] data_in,
	input wire logic  [15:0] data_out,
	input wire logic         data_lo_oe
);
	// pins idle at time zero
	initial begin
		{reg_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n} = 5'h1F;
		addr = 11'h000;
		data_in = 16'h0000;
	end
	// one byte or word cycle, held five edges to outlast the synchronisers
	task automatic cycle(input logic wr, input logic hi, input logic [10:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic oe);
		@(posedge sys_clk);
		reg_sel_n <= 1'b0;
		low_byte_enable_n <= 1'b0;
		high_byte_enable_n <= !hi;
		rd_n <= wr;
		wr_n <= !wr;
		addr <= a;
		// upper byte is junk: the card must ignore it
		data_in <= {~d, d};
		repeat (5) @(posedge sys_clk);
		#1;
		q = data_out[7:0];
		oe = data_lo_oe;
		@(posedge sys_clk);
		{reg_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n} <= 5'h1F;
		data_in <= ~data_in;
		repeat (4) @(posedge sys_clk);
	endtask : cycle
endmodule : host_socket_model

// ### bench/attribute_config_regs_tb_top.sv
`timescale 1ns/1ps
module attribute_config_regs_tb_top
	import attr_cfg_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst_n;
	logic        reg_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n;
	logic [10:0] addr;
	logic [15:0] data_in, data_out;
	logic        data_lo_oe, status_change_out_n, irq_out_n, core_reset, power_save, ready_out;
	logic [7:0]  card_info_table_addr, card_info_table_data, q;
	logic        core_irq_req, irq_disable_n, core_busy, host_command, drive_number, oe;
	logic        busy_seen, irq_seen;
	map_mode_t   map_mode;
	int          bad_count = 0;
	int          tests_run = 0;
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	// note any busy phase of the ready line and any low on the interrupt pin
	always @(posedge sys_clk) begin
		if (rst_n && ready_out === 1'b0) busy_seen <= 1'b1;
		if (rst_n && irq_out_n === 1'b0) irq_seen <= 1'b1;
	end
	host_socket_model host_u (.sys_clk(sys_clk), .reg_sel_n(reg_sel_n),
		.low_byte_enable_n(low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n),
		.rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
		.data_lo_oe(data_lo_oe));
	// short idle and switch times keep the run brief
	attribute_config_regs #(.IDLE_CYC(200), .SWITCH_CYC(4)) dut_u (.sys_clk(sys_clk),
		.rst_n(rst_n), .reg_sel_n(reg_sel_n), .low_byte_enable_n(low_byte_enable_n),
		.high_byte_enable_n(high_byte_enable_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_lo_oe(data_lo_oe), .data_hi_oe(),
		.status_change_out_n(status_change_out_n), .irq_out_n(irq_out_n),
		.card_info_table_addr(card_info_table_addr), .card_info_table_data(card_info_table_data),
		.core_irq_req(core_irq_req), .irq_disable_n(irq_disable_n), .core_busy(core_busy),
		.host_command(host_command), .core_reset(core_reset), .power_save(power_save),
		.ready_out(ready_out), .map_mode(map_mode), .drive_number(drive_number));
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t bit %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit
	task automatic rd(input logic [9:0] a);
		host_u.cycle(1'b0, 1'b0, {1'b0, a}, 8'h00, q, oe);
	endtask : rd
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		host_u.cycle(1'b1, 1'b0, {1'b0, a}, d, q, oe);
	endtask : wr
	// bounded wait for a power state
	task automatic wait_pwr(input logic v, input int lim);
		int n;
		n = 0;
		while (power_save !== v && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		#1;
		cmp_bit(power_save, v);
	endtask : wait_pwr
	task automatic test_end(input string s);
		$display("test %s done", s);
	endtask : test_end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		$display("BAD %0t run did not finish", $time);
		final_report();
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		{core_irq_req, host_command, busy_seen, irq_seen} = 4'h0;
		{irq_disable_n, core_busy} = 2'b11;
		card_info_table_data = 8'h5A;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(OFF_CONFIG_OPTION); cmp_byte(q, 8'h00);
		rd(OFF_SLOT_AND_UNIT); cmp_byte(q, 8'h00);
		cmp_bit(map_mode === MAP_MEMORY, 1'b1);
		wr(OFF_LINE_SUBSTITUTE, 8'h03);
		rd(OFF_LINE_SUBSTITUTE); cmp_byte(q & 8'hFD, 8'h0C);
		test_end("reset");
		rd(10'h010); cmp_byte(q, 8'h5A);
		cmp_byte(card_info_table_addr, 8'h08);
		wr(10'h000, 8'h81);
		wr(10'h201, 8'h41);
		rd(10'h201); cmp_bit(oe, 1'b0);
		rd(OFF_CONFIG_OPTION); cmp_byte(q, 8'h00);
		test_end("refusals");
		// slot register written before any index
		wr(OFF_SLOT_AND_UNIT, 8'h1F);
		rd(OFF_SLOT_AND_UNIT); cmp_byte(q, 8'h10);
		cmp_bit(drive_number, 1'b1);
		// every index code, level bit toggling, word cycles on odd passes
		for (int i = 0; i < 4; i++) begin
			host_u.cycle(1'b1, i[0], {1'b0, OFF_CONFIG_OPTION}, {1'b0, i[0], 4'h0, i[1:0]}, q, oe);
			host_u.cycle(1'b0, i[0], {1'b0, OFF_CONFIG_OPTION}, 8'h00, q, oe);
			cmp_byte(q, {1'b0, i[0], 4'h0, i[1:0]});
			cmp_bit(map_mode === map_mode_t'(i[1:0]), 1'b1);
		end
		test_end("index");
		wr(OFF_CONFIG_AND_STATE, 8'h60);
		wr(OFF_LINE_SUBSTITUTE, 8'h03);
		rd(OFF_CONFIG_AND_STATE); cmp_byte(q, 8'h60);
		wr(OFF_LINE_SUBSTITUTE, 8'h22);
		cmp_bit(status_change_out_n, 1'b0);
		rd(OFF_CONFIG_AND_STATE); cmp_byte(q, 8'hE0);
		wr(OFF_LINE_SUBSTITUTE, 8'h00);
		rd(OFF_LINE_SUBSTITUTE); cmp_byte(q & 8'h30, 8'h20);
		wr(OFF_CONFIG_AND_STATE, 8'h20);
		cmp_bit(status_change_out_n, 1'b1);
		// core idles from here, so the ready line is free to toggle
		@(posedge sys_clk) core_busy <= 1'b0;
		wr(OFF_LINE_SUBSTITUTE, 8'h03);
		test_end("status");
		busy_seen = 1'b0;
		wr(OFF_CONFIG_AND_STATE, 8'h04);
		wait_pwr(1'b1, 40);
		cmp_bit(busy_seen, 1'b1);
		rd(OFF_LINE_SUBSTITUTE); cmp_byte(q & 8'h20, 8'h20);
		wr(OFF_CONFIG_AND_STATE, 8'h00);
		wait_pwr(1'b0, 40);
		wr(OFF_LINE_SUBSTITUTE, 8'h03);
		test_end("power");
		@(posedge sys_clk) core_irq_req <= 1'b1;
		rd(OFF_CONFIG_AND_STATE); cmp_bit(q[1], 1'b1);
		cmp_bit(irq_out_n, 1'b0);
		@(posedge sys_clk) irq_disable_n <= 1'b0;
		rd(OFF_CONFIG_AND_STATE); cmp_bit(q[1], 1'b0);
		cmp_bit(irq_out_n, 1'b1);
		// pulse mode, io index kept
		wr(OFF_CONFIG_OPTION, 8'h03);
		irq_seen = 1'b0;
		@(posedge sys_clk) irq_disable_n <= 1'b1;
		rd(OFF_CONFIG_AND_STATE); cmp_bit(q[1], 1'b1);
		cmp_bit(irq_seen, 1'b1);
		cmp_bit(irq_out_n, 1'b1);
		@(posedge sys_clk) core_irq_req <= 1'b0;
		test_end("pending");
		wr(OFF_CONFIG_OPTION, 8'h80);
		cmp_bit(core_reset, 1'b1);
		rd(OFF_CONFIG_OPTION); cmp_byte(q, 8'h80);
		wr(OFF_CONFIG_OPTION, 8'h00);
		cmp_bit(core_reset, 1'b0);
		rd(OFF_SLOT_AND_UNIT); cmp_byte(q, 8'h00);
		cmp_bit(map_mode === MAP_MEMORY, 1'b1);
		rd(OFF_LINE_SUBSTITUTE); cmp_byte(q & 8'h30, 8'h00);
		test_end("soft reset");
		@(posedge sys_clk) core_busy <= 1'b0;
		wait_pwr(1'b1, 600);
		@(posedge sys_clk) host_command <= 1'b1;
		@(posedge sys_clk) host_command <= 1'b0;
		wait_pwr(1'b0, 40);
		test_end("auto power");
		final_report();
	end
endmodule : attribute_config_regs_tb_top
